// [rtl/spsc_defs.svh]
// Offsets, field positions and timing counts of the strap capture block.
`ifndef SPSC_DEFS_SVH
`define SPSC_DEFS_SVH
// Number of lane groups (port pairs n, n+1 with n = 0, 2, 4, 6).
`define SPSC_NGRP 4
// Straps must stand this many core clock cycles after reset release.
`define SPSC_HOLD_CYC 10
// Capture takes place on this cycle count after release (last stable cycle).
`define SPSC_CAP_CYC 4'h9
// Register byte offsets.
`define SPSC_CLKSEL_OFS 12'h000
`define SPSC_STATUS_OFS 12'h004
`define SPSC_CTRL_OFS 12'h008
// Clock-selection register fields, one byte lane per group.
`define SPSC_X1_BIT 0
`define SPSC_X4_BIT 1
`define SPSC_OVR_BIT 2
// Control register fields.
`define SPSC_SELF_RST_BIT 0
`define SPSC_TEST_MODE_BIT 1
// Status register field positions per byte lane.
`define SPSC_ST_WIDTH_BIT 0
`define SPSC_ST_LPD_BIT 1
`define SPSC_ST_UPD_BIT 2
`define SPSC_ST_PN_BIT 3
`define SPSC_ST_PN1_BIT 4
`define SPSC_ST_DONE_BIT 7
`endif

// [rtl/spsc_pkg.sv]
// Types shared by the strap capture block.
package spsc_pkg;
  // Capture sequencer states.
  typedef enum logic [1:0] {SPSC_WAIT, SPSC_COUNT, SPSC_DONE} spsc_state_e;
  // Captured settings of one lane group.
  typedef struct packed {
    logic width_1x;
    logic lower_pd;
    logic upper_pd;
  } spsc_grp_s;
  typedef logic [3:0] spsc_grp_t;
endpackage

// [rtl/spsc_grp_if.sv]
// Interface carrying one lane group's settings into the power decoder.
`timescale 1ns/10ps
`default_nettype none
interface spsc_grp_if;
  spsc_pkg::spsc_grp_s cfg; // Effective straps after any override.
  logic pd_n; // Port n powered down.
  logic pd_n1; // Port n+1 powered down.
  logic quad; // Group runs as one four-lane port.
  modport src (output cfg, input pd_n, pd_n1, quad);
  modport dec (input cfg, output pd_n, pd_n1, quad);
endinterface
`default_nettype wire

// [rtl/spsc_pwr_dec.sv]
// Power and width decoder for one lane group.
`timescale 1ns/10ps
`default_nettype none
module spsc_pwr_dec (
  spsc_grp_if.dec g
);
  import spsc_pkg::*;
  // Width strap 0 selects one four-lane port.
  assign g.quad = ~g.cfg.width_1x; // RULE_01
  // Lower power-down kills the whole macro, both ports and all four lanes.
  assign g.pd_n = g.cfg.lower_pd; // RULE_04 RULE_05 RULE_06
  // Upper port follows its own strap only while the lower strap allows it.
  assign g.pd_n1 = g.cfg.lower_pd | g.cfg.upper_pd; // RULE_04 RULE_07
endmodule // spsc_pwr_dec
`default_nettype wire

// [rtl/spsc_top.sv]
// Strap capture of serial port width and power-down settings with an AHB-Lite slave.
//
// Overview of operation
// RULE_01: Width strap 0 is quad lane, 1 dual.
// RULE_02: Board holds straps ten cycles after release.
// RULE_03: Straps captured once at release, then ignored.
// RULE_04: Lower power-down 1 powers off both ports.
// RULE_05: Lower 0 powers port n; upper follows strap.
// RULE_06: Lower power-down governs all four macro lanes.
// RULE_07: Upper strap powers port n+1 up or down.
// RULE_08: Quad width needs upper port powered down; not enforced, port n+1 follows the upper power-down value in quad mode too.
// RULE_09: Single-lane field overrides lower power-down value.
// RULE_10: Quad-lane field overrides upper power-down value.
// RULE_11: Strap pins driven only in test mode.
// RULE_12: Release is hard reset or self-reset end.
// RULE_13: Captured values held in registers until reset.
//
// Chosen here: the AHB-Lite register port and the register offsets.
`timescale 1ns/10ps
`default_nettype none
`include "spsc_defs.svh"
module spsc_top (
  input wire logic hclk,
  input wire logic hresetn,
  input wire logic hsel,
  input wire logic [11:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  output logic [31:0] hrdata,
  output logic hreadyout,
  output logic hresp,
  input wire logic [3:0] lane_width_strap_i,
  output logic [3:0] lane_width_strap_o,
  output logic [3:0] lane_width_strap_oe,
  input wire logic [3:0] lower_port_powerdown_strap_i,
  output logic [3:0] lower_port_powerdown_strap_o,
  output logic [3:0] lower_port_powerdown_strap_oe,
  input wire logic [3:0] upper_port_powerdown_strap_i,
  output logic [3:0] upper_port_powerdown_strap_o,
  output logic [3:0] upper_port_powerdown_strap_oe,
  output spsc_pkg::spsc_grp_t quad_mode,
  output spsc_pkg::spsc_grp_t port_n_pd,
  output spsc_pkg::spsc_grp_t port_n1_pd,
  output logic cfg_valid
);
  import spsc_pkg::*;

  // Capture sequencer state and its cycle counter.
  spsc_state_e state_r;
  logic [3:0] cnt_r;
  // Captured straps, one set per group.
  logic [3:0] width_r, lpd_r, upd_r;
  // Software overrides held in the clock-selection register.
  logic [3:0] x1_r, x4_r, ovr_r;
  // Self-reset request and test-mode enable from the control register.
  logic self_rst_r, test_mode_r;
  // Registered data phase of the bus.
  logic wr_pend_r;
  logic [11:0] addr_r;
  // Decoded outputs of each group before registering.
  logic [3:0] quad_w, pdn_w, pdn1_w;

  // One field of the clock-selection byte belonging to group g.
  // A select on a call result is not portable, so the field position is an argument.
  function automatic logic clksel_bit(input logic [31:0] d, input int g, input int f);
    clksel_bit = d[g*8 + f];
  endfunction

  // Address decode used by both the write path and the read path.
  function automatic logic [1:0] reg_sel(input logic [11:0] a);
    case (a)
      `SPSC_CLKSEL_OFS: reg_sel = 2'h1;
      `SPSC_STATUS_OFS: reg_sel = 2'h2;
      `SPSC_CTRL_OFS: reg_sel = 2'h3;
      default: reg_sel = 2'h0;
    endcase
  endfunction

  // Sequencer: count out the hold window after hard reset or self-reset, then capture once.
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      state_r <= SPSC_WAIT;
      cnt_r <= 4'h0;
    end else if (self_rst_r) begin
      // Ending a self-reset counts as a fresh release.
      state_r <= SPSC_WAIT; // RULE_12
      cnt_r <= 4'h0;
    end else begin
      case (state_r)
        SPSC_WAIT: begin
          state_r <= SPSC_COUNT;
          cnt_r <= 4'h0;
        end
        SPSC_COUNT: begin
          // Straps are stable for the whole window, so the last cycle is sampled.
          if (cnt_r == `SPSC_CAP_CYC) begin
            state_r <= SPSC_DONE; // RULE_02
          end else begin
            cnt_r <= cnt_r + 4'h1;
          end
        end
        SPSC_DONE: begin
          state_r <= SPSC_DONE;
        end
        default: begin
          state_r <= SPSC_WAIT;
        end
      endcase
    end
  end

  // Strap registers load only at the capture cycle; pin changes later are ignored.
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      width_r <= 4'h0;
      lpd_r <= 4'h0;
      upd_r <= 4'h0;
    end else if (state_r == SPSC_COUNT && cnt_r == `SPSC_CAP_CYC && !self_rst_r) begin
      width_r <= lane_width_strap_i; // RULE_03 RULE_13
      lpd_r <= lower_port_powerdown_strap_i; // RULE_03 RULE_13
      upd_r <= upper_port_powerdown_strap_i; // RULE_03 RULE_13
    end
  end

  // Write data phase of the bus slave; the slave never inserts wait states.
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      wr_pend_r <= 1'b0;
      addr_r <= 12'h000;
    end else if (hready) begin
      wr_pend_r <= hsel & htrans[1] & hwrite;
      addr_r <= haddr;
    end
  end

  // Clock-selection and control registers written by software.
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      x1_r <= 4'h0;
      x4_r <= 4'h0;
      ovr_r <= 4'h0;
      self_rst_r <= 1'b0;
      test_mode_r <= 1'b0;
    end else begin
      // Self-reset request is a one-cycle pulse.
      self_rst_r <= 1'b0;
      if (wr_pend_r && reg_sel(addr_r) == 2'h1) begin
        for (int g = 0; g < `SPSC_NGRP; g++) begin
          x1_r[g] <= clksel_bit(hwdata, g, `SPSC_X1_BIT); // RULE_09
          x4_r[g] <= clksel_bit(hwdata, g, `SPSC_X4_BIT); // RULE_10
          ovr_r[g] <= clksel_bit(hwdata, g, `SPSC_OVR_BIT);
        end
      end
      if (wr_pend_r && reg_sel(addr_r) == 2'h3) begin
        self_rst_r <= hwdata[`SPSC_SELF_RST_BIT];
        test_mode_r <= hwdata[`SPSC_TEST_MODE_BIT];
      end
    end
  end

  // One decoder per group; the override substitutes software values for the two power-down straps.
  generate
    for (genvar g = 0; g < `SPSC_NGRP; g++) begin : g_grp
      spsc_grp_if gi ();
      assign gi.cfg.width_1x = width_r[g];
      assign gi.cfg.lower_pd = ovr_r[g] ? x1_r[g] : lpd_r[g]; // RULE_09
      assign gi.cfg.upper_pd = ovr_r[g] ? x4_r[g] : upd_r[g]; // RULE_10
      spsc_pwr_dec u_dec (
        .g(gi)
      );
      assign quad_w[g] = gi.quad;
      assign pdn_w[g] = gi.pd_n;
      assign pdn1_w[g] = gi.pd_n1;
    end
  endgenerate

  // Outputs held in power-down until capture completes, so no lane wakes on unknown straps.
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      quad_mode <= 4'h0;
      port_n_pd <= 4'hf;
      port_n1_pd <= 4'hf;
      cfg_valid <= 1'b0;
    end else begin
      cfg_valid <= (state_r == SPSC_DONE);
      quad_mode <= (state_r == SPSC_DONE) ? quad_w : 4'h0; // RULE_01
      port_n_pd <= (state_r == SPSC_DONE) ? pdn_w : 4'hf; // RULE_04 RULE_06
      port_n1_pd <= (state_r == SPSC_DONE) ? pdn1_w : 4'hf; // RULE_05 RULE_07
    end
  end

  // Read data: status shows the captured straps and the decoded power state.
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      hrdata <= 32'h0000_0000;
    end else if (hready && hsel && htrans[1] && !hwrite) begin
      hrdata <= 32'h0000_0000;
      for (int g = 0; g < `SPSC_NGRP; g++) begin
        case (reg_sel(haddr))
          2'h1: begin
            hrdata[g*8 + `SPSC_X1_BIT] <= x1_r[g];
            hrdata[g*8 + `SPSC_X4_BIT] <= x4_r[g];
            hrdata[g*8 + `SPSC_OVR_BIT] <= ovr_r[g];
          end
          2'h2: begin
            hrdata[g*8 + `SPSC_ST_WIDTH_BIT] <= width_r[g];
            hrdata[g*8 + `SPSC_ST_LPD_BIT] <= lpd_r[g];
            hrdata[g*8 + `SPSC_ST_UPD_BIT] <= upd_r[g];
            hrdata[g*8 + `SPSC_ST_PN_BIT] <= port_n_pd[g];
            hrdata[g*8 + `SPSC_ST_PN1_BIT] <= port_n1_pd[g];
            hrdata[g*8 + `SPSC_ST_DONE_BIT] <= cfg_valid;
          end
          2'h3: begin
            if (g == 0) begin
              hrdata[`SPSC_TEST_MODE_BIT] <= test_mode_r;
            end
          end
          default: begin
          end
        endcase
      end
    end
  end

  // Zero-wait slave with an always-OKAY response.
  assign hreadyout = 1'b1;
  assign hresp = 1'b0;

  // Strap pins drive the captured values back out only in test mode.
  assign lane_width_strap_o = width_r; // RULE_11
  assign lower_port_powerdown_strap_o = lpd_r; // RULE_11
  assign upper_port_powerdown_strap_o = upd_r; // RULE_11
  assign lane_width_strap_oe = {4{test_mode_r}}; // RULE_11
  assign lower_port_powerdown_strap_oe = {4{test_mode_r}}; // RULE_11
  assign upper_port_powerdown_strap_oe = {4{test_mode_r}}; // RULE_11

  // Captured straps change only on the capture cycle.
  a_strap_hold: assert property (@(posedge hclk) disable iff (!hresetn)
    (state_r == SPSC_DONE && !self_rst_r) |=> $stable(width_r) && $stable(lpd_r) && $stable(upd_r)) // RULE_03
    else $error("captured strap changed after capture");
  // Lower power-down forces both ports down once configured.
  a_lower_pd_both: assert property (@(posedge hclk) disable iff (!hresetn)
    (state_r == SPSC_DONE && pdn_w[0]) |=> (port_n_pd[0] && port_n1_pd[0])) // RULE_04
    else $error("lower power-down did not power off both ports");
  // Upper port follows its strap while the lower port is up.
  a_upper_follow: assert property (@(posedge hclk) disable iff (!hresetn)
    (state_r == SPSC_DONE && !ovr_r[0] && !lpd_r[0]) |=> (port_n1_pd[0] == $past(upd_r[0]))) // RULE_05 RULE_07
    else $error("upper port power does not follow its strap");
  // Width strap 0 gives quad mode.
  a_quad_width: assert property (@(posedge hclk) disable iff (!hresetn)
    (state_r == SPSC_DONE) |=> (quad_mode == ~$past(width_r))) // RULE_01
    else $error("quad mode does not match width strap");
  // Capture completes ten cycles after release.
  // The sampled reset keeps the release edge itself, still in reset, from starting an attempt.
  a_capture_time: assert property (@(posedge hclk) disable iff (!hresetn)
    (hresetn && state_r == SPSC_WAIT && !self_rst_r) |-> ##11 (state_r == SPSC_DONE || $past(self_rst_r))) // RULE_02 RULE_12
    else $error("capture not done ten cycles after release");
  // Pins are driven only in test mode.
  a_test_drive: assert property (@(posedge hclk) disable iff (!hresetn)
    (lane_width_strap_oe != 4'h0) |-> test_mode_r) // RULE_11
    else $error("strap pin driven outside test mode");
  // Single-lane field replaces the lower strap under override.
  a_x1_override: assert property (@(posedge hclk) disable iff (!hresetn)
    (state_r == SPSC_DONE && ovr_r[0]) |=> (port_n_pd[0] == $past(x1_r[0]))) // RULE_09
    else $error("single-lane override not applied");
  // Quad-lane field replaces the upper strap under override.
  a_x4_override: assert property (@(posedge hclk) disable iff (!hresetn)
    (state_r == SPSC_DONE && ovr_r[0] && !x1_r[0]) |=> (port_n1_pd[0] == $past(x4_r[0]))) // RULE_10
    else $error("quad-lane override not applied");
endmodule // spsc_top
`default_nettype wire

// [tb/spsc_board.sv]
// Board tie-off model for the strap pins of the strap capture block.
`timescale 1ns/10ps
`default_nettype none
module spsc_board (
  input wire logic hclk,
  input wire logic hresetn,
  input wire logic [11:0] want,
  input wire logic [11:0] dev_o,
  input wire logic [11:0] dev_oe,
  output logic [11:0] pin
);
  logic [11:0] tie_r; // Levels set by the resistors: upper, lower, width.
  logic [3:0] cnt_r; // Cycles since release, saturating at 15.
  // Counts past the hold window so a board change never lands inside it.
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn)
      cnt_r <= 4'h0;
    else if (cnt_r != 4'hf)
      cnt_r <= cnt_r + 4'h1;
  end
  // New tie-offs only in reset or well after the window; quad groups keep port n+1 off.
  always_ff @(posedge hclk) begin
    if (!hresetn || cnt_r == 4'hf)
      tie_r <= {want[11:8] | ~want[3:0], want[7:0]};
  end
  // The pin shows the device level while it drives, else the resistor level.
  assign pin = (dev_oe & dev_o) | (~dev_oe & tie_r);
endmodule // spsc_board
`default_nettype wire

// [tb/tb.sv]
// Self-checking bench for the strap capture block.
`timescale 1ns/10ps
`default_nettype none
module tb;
  import spsc_pkg::*;
  logic hclk = 1'b0; // Core clock, 8 ns.
  logic hresetn = 1'b0; // Hard reset, active low.
  logic hsel = 1'b0;
  logic [11:0] haddr = 12'h000;
  logic [1:0] htrans = 2'b00;
  logic hwrite = 1'b0;
  logic [31:0] hwdata = 32'h0;
  logic [31:0] hrdata;
  logic hreadyout;
  logic hresp;
  logic [11:0] want = 12'h000; // Board tie-offs: upper, lower, width.
  logic [11:0] pin;
  logic [11:0] dev_o;
  logic [11:0] dev_oe;
  spsc_grp_t quad_mode;
  spsc_grp_t port_n_pd;
  spsc_grp_t port_n1_pd;
  logic cfg_valid;
  logic [31:0] q;
  logic [11:0] sv;
  int n;
  int n_mismatch = 0;
  int checks = 0;
  int cyc = 0;
  always #4 hclk = ~hclk;
  spsc_top u_dut (.hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr), .htrans(htrans),
    .hwrite(hwrite), .hsize(3'b010), .hwdata(hwdata), .hready(hreadyout), .hrdata(hrdata),
    .hreadyout(hreadyout), .hresp(hresp), .lane_width_strap_i(pin[3:0]),
    .lane_width_strap_o(dev_o[3:0]), .lane_width_strap_oe(dev_oe[3:0]),
    .lower_port_powerdown_strap_i(pin[7:4]), .lower_port_powerdown_strap_o(dev_o[7:4]),
    .lower_port_powerdown_strap_oe(dev_oe[7:4]), .upper_port_powerdown_strap_i(pin[11:8]),
    .upper_port_powerdown_strap_o(dev_o[11:8]), .upper_port_powerdown_strap_oe(dev_oe[11:8]),
    .quad_mode(quad_mode), .port_n_pd(port_n_pd), .port_n1_pd(port_n1_pd), .cfg_valid(cfg_valid));
  spsc_board u_board (.hclk(hclk), .hresetn(hresetn), .want(want), .dev_o(dev_o), .dev_oe(dev_oe),
    .pin(pin));
  // Strap levels the board really presents.
  function automatic logic [11:0] eff(input logic [11:0] w);
    eff = {w[11:8] | ~w[3:0], w[7:0]};
  endfunction
  // Expected {port_n1_pd, port_n_pd, quad_mode} for given strap levels.
  function automatic logic [11:0] dec(input logic [11:0] s);
    dec = {s[7:4] | s[11:8], s[7:4], ~s[3:0]};
  endfunction
  // Expected status word once capture is done.
  function automatic logic [31:0] stat(input logic [11:0] s);
    for (int g = 0; g < 4; g++)
      stat[8*g +: 8] = {3'b100, s[4+g] | s[8+g], s[4+g], s[8+g], s[4+g], s[g]};
  endfunction
  task automatic chk(input string what, input logic [31:0] got, input logic [31:0] exp);
    checks++;
    if (got !== exp) begin
      n_mismatch++;
      $display("ERROR %s expected %h seen %h", what, exp, got);
    end
  endtask
  // One single transfer; entered just after a rising edge, returns on the data-phase edge.
  task automatic bus(input logic w, input logic [11:0] a, input logic [31:0] d);
    hsel <= 1'b1;
    haddr <= a;
    hwrite <= w;
    htrans <= 2'b10;
    do @(posedge hclk); while (hreadyout !== 1'b1);
    hsel <= 1'b0;
    htrans <= 2'b00;
    hwdata <= d;
    do @(posedge hclk); while (hreadyout !== 1'b1);
    q = hrdata;
  endtask
  // Waits for the capture to finish, bounded so a stuck sequencer cannot hang the run.
  task automatic wait_valid();
    n = 0;
    do begin
      @(posedge hclk);
      #1;
      n++;
    end while (cfg_valid !== 1'b1 && n < 40);
  endtask
  task automatic stop_test();
    $display("checks %0d mismatches %0d", checks, n_mismatch);
    if (n_mismatch == 0 && checks > 0)
      $display("TEST PASSED");
    else
      $display("TEST FAILED");
    $finish;
  endtask
  // Cuts a hang short well above the hundred or so cycles the tests need.
  always @(posedge hclk) begin
    cyc++;
    if (cyc == 3000) begin
      n_mismatch++;
      stop_test();
    end
  end
  initial begin
    want <= 12'ha4e;
    repeat (8) @(posedge hclk);
    chk("pd_in_reset", {port_n1_pd, port_n_pd, cfg_valid}, 9'h1fe);
    hresetn <= 1'b1;
    wait_valid();
    chk("capture_cycle", 32'(n), 32'd12);
    chk("outputs", {port_n1_pd, port_n_pd, quad_mode}, dec(eff(12'ha4e)));
    $display("test capture done");
    want <= 12'h0f1;
    repeat (20) @(posedge hclk);
    chk("held", {port_n1_pd, port_n_pd, quad_mode}, dec(eff(12'ha4e)));
    bus(1'b0, 12'h004, 32'h0);
    chk("status", q, stat(eff(12'ha4e)));
    bus(1'b1, 12'h004, 32'h0);
    bus(1'b0, 12'h004, 32'h0);
    chk("status_ro", q, stat(eff(12'ha4e)));
    bus(1'b1, 12'h00c, 32'hffffffff);
    bus(1'b0, 12'h00c, 32'h0);
    chk("unmapped", q, 32'h0);
    chk("hresp", hresp, 32'h0);
    $display("test hold done");
    bus(1'b1, 12'h000, 32'h00060504);
    bus(1'b0, 12'h000, 32'h0);
    chk("clksel", q, 32'h00060504);
    sv = eff(12'ha4e);
    sv[6:4] = 3'b010;
    sv[10:8] = 3'b100;
    repeat (2) @(posedge hclk);
    chk("override", {port_n1_pd, port_n_pd, quad_mode}, dec(sv));
    bus(1'b1, 12'h000, 32'h0);
    repeat (2) @(posedge hclk);
    chk("no_override", {port_n1_pd, port_n_pd, quad_mode}, dec(eff(12'ha4e)));
    $display("test override done");
    chk("oe_idle", dev_oe, 12'h000);
    bus(1'b1, 12'h008, 32'h2);
    repeat (2) @(posedge hclk);
    chk("oe_test", dev_oe, 12'hfff);
    chk("o_test", dev_o, eff(12'ha4e));
    bus(1'b1, 12'h008, 32'h0);
    repeat (2) @(posedge hclk);
    chk("oe_off", dev_oe, 12'h000);
    $display("test testmode done");
    want <= 12'h427;
    repeat (2) @(posedge hclk);
    bus(1'b1, 12'h008, 32'h1);
    // The pulse stands one cycle and the outputs follow one cycle later.
    repeat (2) @(posedge hclk);
    #1;
    chk("self_rst_pd", {port_n_pd, cfg_valid}, 5'h1e);
    wait_valid();
    chk("recapture_cycle", 32'(n), 32'd11);
    chk("recapture", {port_n1_pd, port_n_pd, quad_mode}, dec(eff(12'h427)));
    @(posedge hclk);
    bus(1'b0, 12'h008, 32'h0);
    chk("ctrl_pulse", q, 32'h0);
    $display("test selfreset done");
    stop_test();
  end
endmodule // tb
`default_nettype wire
